// file: hdl/arh_readout.sv
// arh_readout: conversion start, busy and result readout handshake of an 8-channel converter
// assumes host pins arrive asynchronously; channel samples arrive on channel_data_i
`timescale 1ns/1ps
`default_nettype none
`include "arh_defines.svh"

module arh_readout #(
   parameter int unsigned CONV_BASE_CYCLES = `ARH_CONV_CYCLES,
   parameter int unsigned NUM_CH           = 8,
   parameter int unsigned DATA_W           = 16
) (
   input  wire logic                     ref_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     cs_n_i,
   input  wire logic                     read_strobe_n_i,
   input  wire logic                     sample_trigger_a_i,
   input  wire logic                     sample_trigger_b_i,
   input  wire logic                     interface_select_i,
   input  wire logic                     byte_serial_select_i,
   input  wire logic [2:0]               oversample_ratio_sel_i,
   input  wire logic [NUM_CH*DATA_W-1:0] channel_data_i,
   output logic      [DATA_W-1:0]        output_data_bus_o,
   output logic                          output_data_bus_oe_o,
   output logic                          serial_out_a_o,
   output logic                          serial_out_b_o,
   output logic                          serial_out_oe_o,
   output logic                          busy_o,
   output logic                          first_channel_flag_o,
   output logic                          first_channel_flag_oe_o,
   output logic      [2:0]               oversample_ratio_o
);

   localparam int unsigned AW   = $clog2(NUM_CH);
   localparam int unsigned HALF = NUM_CH / 2;
   localparam int unsigned BW   = $clog2(DATA_W);

   // conversion length for a ratio code; illegal codes fall back to no oversampling
   function automatic logic [`ARH_CNT_W-1:0] conv_cycles(input logic [2:0] os);
      logic [`ARH_CNT_W-1:0] base;
      base = `ARH_CNT_W'(CONV_BASE_CYCLES);
      if (os > `ARH_OSR_MAX) begin
         conv_cycles = base;
      end else begin
         conv_cycles = base << os;
      end
   endfunction

   // pin synchroniser: three stages, a change counts once stages two and three agree
   logic [`ARH_PIN_W-1:0] pin_raw;
   logic [`ARH_PIN_W-1:0] s1_q, s2_q, s3_q, pin_q;
   logic [`ARH_PIN_W-1:0] pin_d;

   assign pin_raw = {oversample_ratio_sel_i, byte_serial_select_i, interface_select_i,
                     sample_trigger_b_i, sample_trigger_a_i, read_strobe_n_i, cs_n_i};

   always_comb begin
      for (int i = 0; i < `ARH_PIN_W; i++) begin
         pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s1_q  <= `ARH_PIN_RESET;
         s2_q  <= `ARH_PIN_RESET;
         s3_q  <= `ARH_PIN_RESET;
         pin_q <= `ARH_PIN_RESET;
      end else begin
         s1_q  <= pin_raw;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         pin_q <= pin_d;
      end
   end

   // edge and level decode of the filtered pins
   logic       cs_low, rd_low, cs_fall, rd_fall, trig_a_rise, trig_b_rise;
   logic       mode_serial, mode_byte;
   logic [2:0] osr_sel;

   assign cs_low      = ~pin_d[`ARH_PIN_CS];
   assign rd_low      = ~pin_d[`ARH_PIN_RD];
   assign cs_fall     = pin_q[`ARH_PIN_CS] & ~pin_d[`ARH_PIN_CS];
   assign rd_fall     = pin_q[`ARH_PIN_RD] & ~pin_d[`ARH_PIN_RD];
   assign trig_a_rise = ~pin_q[`ARH_PIN_TRIG_A] & pin_d[`ARH_PIN_TRIG_A];
   assign trig_b_rise = ~pin_q[`ARH_PIN_TRIG_B] & pin_d[`ARH_PIN_TRIG_B];
   assign mode_serial = pin_d[`ARH_PIN_IF_SEL] & ~pin_d[`ARH_PIN_BYTE_SEL];
   assign mode_byte   = pin_d[`ARH_PIN_IF_SEL] & pin_d[`ARH_PIN_BYTE_SEL];
   assign osr_sel     = pin_d[`ARH_PIN_OS_MSB:`ARH_PIN_OS_LSB];

   // conversion sequencer
   arh_pkg::arh_state_e         state_q, state_d;
   logic [`ARH_CNT_W-1:0]       cnt_q, cnt_d;
   logic                        seen_a_q, seen_a_d, seen_b_q, seen_b_d;
   logic [NUM_CH*DATA_W-1:0]    hold_q, hold_d;
   logic [AW-1:0]               lat_idx_q, lat_idx_d;
   logic                        busy_d;
   logic [2:0]                  osr_q, osr_d;
   logic                        mem_we;
   logic [DATA_W-1:0]           mem_wdata;

   always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      seen_a_d  = seen_a_q;
      seen_b_d  = seen_b_q;
      hold_d    = hold_q;
      lat_idx_d = lat_idx_q;
      osr_d     = osr_q;
      mem_we    = 1'b0;
      mem_wdata = hold_q[lat_idx_q*DATA_W +: DATA_W];
      unique case (state_q)
         arh_pkg::ARH_ST_IDLE: begin
            // start edges only count while idle
            if (trig_a_rise) begin
               seen_a_d = 1'b1;
               hold_d[HALF*DATA_W-1:0] = channel_data_i[HALF*DATA_W-1:0];
            end
            if (trig_b_rise) begin
               seen_b_d = 1'b1;
               hold_d[NUM_CH*DATA_W-1:HALF*DATA_W] =
                  channel_data_i[NUM_CH*DATA_W-1:HALF*DATA_W];
            end
            if (seen_a_d && seen_b_d) begin
               state_d  = arh_pkg::ARH_ST_CONV;
               osr_d    = osr_sel;
               cnt_d    = conv_cycles(osr_sel) - `ARH_CNT_W'(1);
               seen_a_d = 1'b0;
               seen_b_d = 1'b0;
            end
         end
         arh_pkg::ARH_ST_CONV: begin
            if (cnt_q == '0) begin
               state_d   = arh_pkg::ARH_ST_LATCH;
               lat_idx_d = '0;
            end else begin
               cnt_d = cnt_q - `ARH_CNT_W'(1);
            end
         end
         arh_pkg::ARH_ST_LATCH: begin
            // one result word per cycle; busy drops only after the last
            mem_we = 1'b1;
            if (lat_idx_q == AW'(NUM_CH - 1)) begin
               state_d = arh_pkg::ARH_ST_IDLE;
            end else begin
               lat_idx_d = lat_idx_q + AW'(1);
            end
         end
         default: begin
            state_d = arh_pkg::ARH_ST_IDLE;
         end
      endcase
      busy_d = (state_d != arh_pkg::ARH_ST_IDLE);
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_q   <= arh_pkg::ARH_ST_IDLE;
         cnt_q     <= '0;
         seen_a_q  <= 1'b0;
         seen_b_q  <= 1'b0;
         hold_q    <= '0;
         lat_idx_q <= '0;
         osr_q     <= '0;
         busy_o    <= 1'b0;
      end else begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         seen_a_q  <= seen_a_d;
         seen_b_q  <= seen_b_d;
         hold_q    <= hold_d;
         lat_idx_q <= lat_idx_d;
         osr_q     <= osr_d;
         busy_o    <= busy_d;
      end
   end

   assign oversample_ratio_o = osr_q;

   // result storage; reads of old results stay valid until the latch phase
   logic [AW-1:0]     addr_a_q, addr_a_d, addr_b_q, addr_b_d;
   logic [DATA_W-1:0] rdata_a, rdata_b;

   arh_result_mem #(
      .DEPTH (NUM_CH),
      .WIDTH (DATA_W)
   ) u_mem (
      .clk_i     (ref_clk_i),
      .rst_i     (rst_i),
      .we_i      (mem_we),
      .waddr_i   (lat_idx_q),
      .wdata_i   (mem_wdata),
      .raddr_a_i (addr_a_q),
      .raddr_b_i (addr_b_q),
      .rdata_a_o (rdata_a),
      .rdata_b_o (rdata_b)
   );

   // readout sequencing within a chip-select frame
   logic [4:0]        rd_cnt_q, rd_cnt_d;
   logic [BW-1:0]     bit_q, bit_d;
   logic              hi_q, hi_d;
   logic              flag_d, flag_oe_d;
   logic [DATA_W-1:0] db_d;
   logic              db_oe_d, so_a_d, so_b_d, so_oe_d;

   always_comb begin
      rd_cnt_d = rd_cnt_q;
      bit_d    = bit_q;
      hi_d     = hi_q;
      addr_a_d = addr_a_q;
      addr_b_d = addr_b_q;
      flag_d   = first_channel_flag_o;
      if (cs_fall) begin
         // new frame restarts at channel one
         rd_cnt_d = '0;
         addr_a_d = '0;
         addr_b_d = AW'(HALF);
         bit_d    = BW'(DATA_W - 1);
         hi_d     = 1'b1;
         flag_d   = mode_serial; // serial frame opens on channel one
      end else if (cs_low && rd_fall && !mode_serial) begin
         if (mode_byte) begin
            addr_a_d = rd_cnt_q[AW:1]; // two strobes per channel
            hi_d     = ~rd_cnt_q[0];   // high byte first
            flag_d   = (rd_cnt_q < 5'h02);
         end else begin
            addr_a_d = rd_cnt_q[AW-1:0];
            flag_d   = (rd_cnt_q == 5'h00);
         end
         rd_cnt_d = rd_cnt_q + 5'h01;
      end else if (cs_low && rd_fall) begin
         // serial clock falling edge moves to the next bit, host samples on the rise
         if (bit_q == '0) begin
            bit_d    = BW'(DATA_W - 1);
            addr_a_d = addr_a_q + AW'(1);
            addr_b_d = addr_b_q + AW'(1);
            flag_d   = 1'b0;
         end else begin
            bit_d = bit_q - BW'(1);
         end
      end
      // a high chip select drops every driver at once
      db_oe_d   = cs_low && rd_low && !mode_serial;
      so_oe_d   = cs_low && mode_serial;
      flag_oe_d = cs_low;
      if (mode_byte) begin
         db_d = {{(DATA_W/2){1'b0}},
                 hi_q ? rdata_a[DATA_W-1:DATA_W/2] : rdata_a[DATA_W/2-1:0]};
      end else begin
         db_d = rdata_a;
      end
      so_a_d = rdata_a[bit_q]; // msb first
      so_b_d = rdata_b[bit_q];
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rd_cnt_q                <= '0;
         bit_q                   <= BW'(DATA_W - 1);
         hi_q                    <= 1'b1;
         addr_a_q                <= '0;
         addr_b_q                <= AW'(HALF);
         output_data_bus_o       <= '0;
         output_data_bus_oe_o    <= 1'b0;
         serial_out_a_o          <= 1'b0;
         serial_out_b_o          <= 1'b0;
         serial_out_oe_o         <= 1'b0;
         first_channel_flag_o    <= 1'b0;
         first_channel_flag_oe_o <= 1'b0;
      end else begin
         rd_cnt_q                <= rd_cnt_d;
         bit_q                   <= bit_d;
         hi_q                    <= hi_d;
         addr_a_q                <= addr_a_d;
         addr_b_q                <= addr_b_d;
         output_data_bus_o       <= db_d;
         output_data_bus_oe_o    <= db_oe_d;
         serial_out_a_o          <= so_a_d;
         serial_out_b_o          <= so_b_d;
         serial_out_oe_o         <= so_oe_d;
         first_channel_flag_o    <= flag_d;
         first_channel_flag_oe_o <= flag_oe_d;
      end
   end

endmodule

`default_nettype wire

// file: hdl/arh_defines.svh
// arh_defines.svh: timing counts, pin vector positions and limits for the readout block
// assumes inclusion by bare name from hdl/ before any module that uses it
`ifndef ARH_DEFINES_SVH
`define ARH_DEFINES_SVH

// clock and conversion timing
`define ARH_CLK_PERIOD_NS 20
`define ARH_CONV_TIME_NS  4000
// least time, so round up to whole cycles
`define ARH_CONV_CYCLES   ((`ARH_CONV_TIME_NS + `ARH_CLK_PERIOD_NS - 1) / `ARH_CLK_PERIOD_NS)

// highest legal oversampling code; codes above it convert without oversampling
`define ARH_OSR_MAX       3'h6

// positions inside the synchronised pin vector
`define ARH_PIN_CS        0
`define ARH_PIN_RD        1
`define ARH_PIN_TRIG_A    2
`define ARH_PIN_TRIG_B    3
`define ARH_PIN_IF_SEL    4
`define ARH_PIN_BYTE_SEL  5
`define ARH_PIN_OS_LSB    6
`define ARH_PIN_OS_MSB    8
`define ARH_PIN_W         9

// pin reset value and counter width
`define ARH_PIN_RESET     9'h003
`define ARH_CNT_W         20

`endif

// file: hdl/arh_pkg.sv
// arh_pkg: types shared by the readout block
// assumes nothing beyond a SystemVerilog compiler
package arh_pkg;

   // conversion sequencer states, one-hot
   typedef enum logic [2:0] {
      ARH_ST_IDLE  = 3'b001,
      ARH_ST_CONV  = 3'b010,
      ARH_ST_LATCH = 3'b100
   } arh_state_e;

endpackage

// file: hdl/arh_result_mem.sv
// arh_result_mem: output data registers, one write port, two registered read ports
// assumes one clock and a synchronous active-high reset that clears every word
`timescale 1ns/1ps
`default_nettype none

module arh_result_mem #(
   parameter int unsigned DEPTH = 8,
   parameter int unsigned WIDTH = 16,
   parameter int unsigned AW    = $clog2(DEPTH)
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             we_i,
   input  wire logic [AW-1:0]    waddr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   input  wire logic [AW-1:0]    raddr_a_i,
   input  wire logic [AW-1:0]    raddr_b_i,
   output logic      [WIDTH-1:0] rdata_a_o,
   output logic      [WIDTH-1:0] rdata_b_o
);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [WIDTH-1:0] rd_a_d;
   logic [WIDTH-1:0] rd_b_d;

   // next contents; reset clears results so a read after reset shows zero
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_d[i] = mem_q[i];
      end
      if (we_i) begin
         mem_d[waddr_i] = wdata_i;
      end
      rd_a_d = mem_q[raddr_a_i];
      rd_b_d = mem_q[raddr_b_i];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         rdata_a_o <= '0;
         rdata_b_o <= '0;
      end else begin
         mem_q     <= mem_d;
         rdata_a_o <= rd_a_d;
         rdata_b_o <= rd_b_d;
      end
   end

endmodule

`default_nettype wire

// file: dv/arh_readout_asserts.sv
// arh_readout_asserts: port-level checks for the readout handshake
// assumes the bind below hands on the design parameters; one clock domain
`timescale 1ns/1ps
`default_nettype none

module arh_readout_asserts #(
   parameter int unsigned CONV_BASE_CYCLES = 4,
   parameter int unsigned DATA_W           = 16
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire logic              cs_n_i,
   input  wire logic              read_strobe_n_i,
   input  wire logic              sample_trigger_a_i,
   input  wire logic              sample_trigger_b_i,
   input  wire logic              interface_select_i,
   input  wire logic              byte_serial_select_i,
   input  wire logic [2:0]        oversample_ratio_sel_i,
   input  wire logic [DATA_W-1:0] output_data_bus_o,
   input  wire logic              output_data_bus_oe_o,
   input  wire logic              serial_out_oe_o,
   input  wire logic              busy_o,
   input  wire logic              first_channel_flag_oe_o,
   input  wire logic [2:0]        oversample_ratio_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   logic [19:0] busy_cnt_q;
   logic [19:0] busy_cnt_d;
   logic [19:0] busy_len;

   // busy run length; code 7 converts as no oversampling
   always_comb begin
      busy_cnt_d = (rst_i || !busy_o) ? 20'h00000 : busy_cnt_q + 20'h00001;
      busy_len = 20'((CONV_BASE_CYCLES << ((oversample_ratio_o == 3'h7) ? 3'h0
                 : oversample_ratio_o)) + 8);
   end
   always_ff @(posedge ref_clk_i) begin
      busy_cnt_q <= busy_cnt_d;
   end

   a_cs_high_off: assert property (
      cs_n_i [*6] |-> !output_data_bus_oe_o && !serial_out_oe_o && !first_channel_flag_oe_o)
      else $error("output driven with chip select high");
   a_frame_needs_cs: assert property (
      (serial_out_oe_o || first_channel_flag_oe_o) |-> $past(cs_n_i, 4) == 1'b0)
      else $error("frame output without chip select low");
   a_bus_needs_rd: assert property (
      $rose(output_data_bus_oe_o) |-> $past(cs_n_i, 4) == 1'b0
      && $past(read_strobe_n_i, 4) == 1'b0) else $error("bus enabled without read strobe");
   a_byte_upper_zero: assert property (
      output_data_bus_oe_o && interface_select_i && byte_serial_select_i
      |-> output_data_bus_o[DATA_W-1:8] == '0) else $error("upper byte not zero");
   a_serial_no_bus: assert property (
      interface_select_i && !byte_serial_select_i |-> !output_data_bus_oe_o)
      else $error("parallel bus driven in serial mode");
   a_ratio_taken: assert property (
      $rose(busy_o) |-> oversample_ratio_o == $past(oversample_ratio_sel_i, 4))
      else $error("ratio code not taken at start");
   a_busy_both: assert property (
      $rose(busy_o) |-> $past(sample_trigger_a_i, 4) && $past(sample_trigger_b_i, 4))
      else $error("busy rose without both starts");
   a_busy_length: assert property (
      $fell(busy_o) |-> busy_cnt_q == busy_len) else $error("busy length wrong");
   a_busy_lockout: assert property (
      $fell(busy_o) |-> !busy_o [*3]) else $error("start taken while busy");

   c_busy: cover property ($rose(busy_o));
   c_flag_frame: cover property ($rose(first_channel_flag_oe_o));
   c_serial_frame: cover property ($rose(serial_out_oe_o));
endmodule

bind arh_readout arh_readout_asserts #(
   .CONV_BASE_CYCLES(CONV_BASE_CYCLES),
   .DATA_W(DATA_W)
) arh_readout_asserts_i (.ref_clk_i, .rst_i, .cs_n_i, .read_strobe_n_i, .sample_trigger_a_i,
   .sample_trigger_b_i, .interface_select_i, .byte_serial_select_i, .oversample_ratio_sel_i,
   .output_data_bus_o, .output_data_bus_oe_o, .serial_out_oe_o, .busy_o,
   .first_channel_flag_oe_o, .oversample_ratio_o);

`default_nettype wire

// file: dv/arh_host_model.sv
// arh_host_model: host controller driving chip select, read strobe and starts
// assumes the bench calls drive() and that pins always stay driven
`timescale 1ns/1ps
`default_nettype none

module arh_host_model (
   input  wire logic ref_clk_i,
   input  wire logic busy_i,
   // idle: not selected, no strobe, starts low; only drive() writes them later
   output logic      cs_n_o             = 1'b1,
   output logic      read_strobe_n_o    = 1'b1,
   output logic      sample_trigger_a_o = 1'b0,
   output logic      sample_trigger_b_o = 1'b0
);

   // one pin level change after an edge (both starts together for sel 4 and up), held n cycles; n sets prompt or slow
   task automatic drive(input int sel, input logic v, input int n);
      while (sel == 1 && !v && busy_i) @(posedge ref_clk_i);
      @(posedge ref_clk_i);
      #1;
      case (sel)
         0: cs_n_o = v;
         1: read_strobe_n_o = v;
         2: sample_trigger_a_o = v;
         3: sample_trigger_b_o = v;
         default: {sample_trigger_a_o, sample_trigger_b_o} = {v, v};
      endcase
      repeat (n) @(posedge ref_clk_i);
      #2;
   endtask
endmodule

`default_nettype wire

// file: dv/arh_readout_bench.sv
// arh_readout_bench: self-checking bench for the readout handshake
// assumes the host model drives the strobes; a short conversion count
`timescale 1ns/1ps
`default_nettype none

module arh_readout_bench;
   localparam int unsigned BASE = 4;
   localparam logic [2:0]  OS_LIST [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
   logic         ref_clk_i = 1'b0;
   logic         rst_i = 1'b1;
   logic         cs_n_i, read_strobe_n_i, sample_trigger_a_i, sample_trigger_b_i;
   logic         interface_select_i, byte_serial_select_i;
   logic [2:0]   oversample_ratio_sel_i, oversample_ratio_o;
   logic [127:0] channel_data_i;
   logic [15:0]  output_data_bus_o;
   logic [15:0]  run_len = 16'h0000, last_len = 16'h0000;
   logic         output_data_bus_oe_o, serial_out_a_o, serial_out_b_o, serial_out_oe_o;
   logic         busy_o, first_channel_flag_o, first_channel_flag_oe_o;
   int           error_cnt = 0, checks = 0, cyc = 0;

   arh_readout #(.CONV_BASE_CYCLES(BASE)) arh_readout_i (.ref_clk_i, .rst_i, .cs_n_i,
      .read_strobe_n_i, .sample_trigger_a_i, .sample_trigger_b_i, .interface_select_i,
      .byte_serial_select_i, .oversample_ratio_sel_i, .channel_data_i, .output_data_bus_o,
      .output_data_bus_oe_o, .serial_out_a_o, .serial_out_b_o, .serial_out_oe_o, .busy_o,
      .first_channel_flag_o, .first_channel_flag_oe_o, .oversample_ratio_o);
   arh_host_model host_i (.ref_clk_i, .busy_i(busy_o), .cs_n_o(cs_n_i),
      .read_strobe_n_o(read_strobe_n_i), .sample_trigger_a_o(sample_trigger_a_i),
      .sample_trigger_b_o(sample_trigger_b_i));

   always #10 ref_clk_i = ~ref_clk_i;

   // busy run length seen at the pins; hang guard
   always @(posedge ref_clk_i) begin
      run_len <= busy_o ? run_len + 16'h0001 : 16'h0000;
      if (!busy_o && run_len != 16'h0000) last_len <= run_len;
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         stop_test();
      end
   end

   function automatic logic [15:0] chv(input int k);
      return {4'hc, 4'(k), 4'h3, 4'(15 - k)};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask

   task automatic t_only_a();
      host_i.drive(2, 1'b1, 20);
      check(16'(busy_o), 16'h0000);
      host_i.drive(3, 1'b1, 8);
      check(16'(busy_o), 16'h0001);
      host_i.drive(4, 1'b0, 30);
      $display("test only_a done");
   endtask

   // wiggle re-raises both starts mid-conversion; they must be ignored
   task automatic t_convert(input logic [2:0] os, input bit wiggle);
      int n;
      @(posedge ref_clk_i);
      #1;
      oversample_ratio_sel_i = os;
      host_i.drive(4, 1'b1, 6);
      if (wiggle) begin
         host_i.drive(4, 1'b0, 4);
         host_i.drive(4, 1'b1, 4);
      end
      n = 0;
      while (busy_o !== 1'b0 && n < 1000) begin
         @(posedge ref_clk_i);
         n++;
      end
      repeat (12) @(posedge ref_clk_i);
      #2;
      check(last_len, 16'((BASE << ((os == 3'h7) ? 0 : os)) + 8));
      check(16'(busy_o), 16'h0000);
      check(16'(oversample_ratio_o), 16'(os));
      host_i.drive(4, 1'b0, 4);
      $display("test convert %0d done", os);
   endtask

   task automatic t_frame(input bit byte_md);
      logic [15:0] ch;
      @(posedge ref_clk_i);
      #1;
      {interface_select_i, byte_serial_select_i} = {byte_md, byte_md};
      host_i.drive(0, 1'b0, 8);
      check(16'(first_channel_flag_oe_o), 16'h0001);
      for (int r = 0; r < (byte_md ? 16 : 8); r++) begin
         ch = chv(byte_md ? r / 2 : r);
         host_i.drive(1, 1'b0, 8);
         check(output_data_bus_o, byte_md ? 16'(r[0] ? ch[7:0] : ch[15:8]) : ch);
         check(16'(first_channel_flag_o), 16'(r < (byte_md ? 2 : 1)));
         check(16'(output_data_bus_oe_o), 16'h0001);
         host_i.drive(1, 1'b1, 8);
         check(16'(output_data_bus_oe_o), 16'h0000);
      end
      host_i.drive(0, 1'b1, 8);
      check(16'({output_data_bus_oe_o, first_channel_flag_oe_o}), 16'h0000);
      $display("test frame %0d done", byte_md);
   endtask

   task automatic t_serial();
      logic [15:0] c0, c4, c1;
      c0 = chv(0);
      c4 = chv(4);
      c1 = chv(1);
      @(posedge ref_clk_i);
      #1;
      {interface_select_i, byte_serial_select_i} = 2'b10;
      host_i.drive(0, 1'b0, 8);
      check(16'({serial_out_oe_o, first_channel_flag_o}), 16'h0003);
      for (int b = 15; b >= 0; b--) begin
         check(16'({serial_out_a_o, serial_out_b_o}), 16'({c0[b], c4[b]}));
         host_i.drive(1, 1'b0, 6);
         host_i.drive(1, 1'b1, 6);
      end
      check(16'({first_channel_flag_o, serial_out_a_o}), 16'(c1[15]));
      host_i.drive(0, 1'b1, 8);
      check(16'(serial_out_oe_o), 16'h0000);
      $display("test serial done");
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // results must come from the samples held at the start edge
   initial begin
      for (int k = 0; k < 8; k++) channel_data_i[k*16 +: 16] = chv(k);
      {oversample_ratio_sel_i, interface_select_i, byte_serial_select_i} = 5'h00;
      repeat (16) @(posedge ref_clk_i);
      #1;
      rst_i = 1'b0;
      t_only_a();
      for (int i = 0; i < 5; i++) t_convert(OS_LIST[i], i == 2);
      channel_data_i = '1;
      t_frame(1'b0);
      t_frame(1'b1);
      t_serial();
      stop_test();
   end
endmodule

`default_nettype wire
